// File: deac_pkg.sv
package deac_pkg;

  // clock and timing
  localparam int unsigned CLK_PERIOD_NS = 100;
  localparam int unsigned WRITE_TIME_NS = 4000000;
  localparam int unsigned PWRT_TIME_NS = 65000000;
  localparam int unsigned WRITE_CYCLES_DEF =
    (WRITE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned PWRT_CYCLES_DEF =
    (PWRT_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned CNT_W = 20;

  // array geometry
  localparam int unsigned ARRAY_DEPTH = 1024;
  localparam int unsigned IDX_W = 10;
  localparam int unsigned HIGH_W = 2;

  // register offsets
  localparam logic [2:0] OFS_CONTROL = 3'h0;
  localparam logic [2:0] OFS_UNLOCK = 3'h1;
  localparam logic [2:0] OFS_BYTE = 3'h2;
  localparam logic [2:0] OFS_IDX_LOW = 3'h3;
  localparam logic [2:0] OFS_IDX_HIGH = 3'h4;
  localparam logic [2:0] OFS_FLAGS_TWO = 3'h5;

  // nvm_control bit positions
  localparam int unsigned BIT_READ = 0;
  localparam int unsigned BIT_WRITE = 1;
  localparam int unsigned BIT_PERMIT = 2;
  localparam int unsigned BIT_ERROR = 3;
  localparam int unsigned BIT_ERASE = 4;
  localparam int unsigned BIT_CFG = 6;
  localparam int unsigned BIT_SPACE = 7;
  // peripheral_flags_two bit position
  localparam int unsigned BIT_DONE = 4;

  // unlock keys and fixed values
  localparam logic [7:0] UNLOCK_FIRST = 8'h55;
  localparam logic [7:0] UNLOCK_SECOND = 8'hAA;
  localparam logic [7:0] ERASED_BYTE = 8'hFF;
  localparam logic [7:0] ZERO_BYTE = 8'h00;

  typedef enum logic [1:0] {
    UNLK_IDLE,
    UNLK_HALF,
    UNLK_ARMED
  } deac_unlock_t;

  typedef struct packed {
    logic [2:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } deac_bus_req_t;

  typedef struct packed {
    logic start;
    logic config_space;
    logic program_space;
    logic erase;
  } deac_ext_t;

  // cleared by resetn, not by por_n
  typedef struct packed {
    logic wr_busy;
    logic erase;
    logic permit;
    deac_unlock_t unlk;
    logic [7:0] idx_low;
    logic [HIGH_W-1:0] idx_high;
    logic [7:0] nvm_byte;
    logic done;
    logic [CNT_W-1:0] wcnt;
    logic [7:0] rdata;
    deac_ext_t ext;
  } deac_state_t;

  // cleared only at power-on
  typedef struct packed {
    logic space;
    logic cfg;
    logic error;
    logic [CNT_W-1:0] pwrt_cnt;
    logic pwrt_done;
  } deac_keep_t;

endpackage

// File: deac_top.sv
// Chosen here: the placing of the registers and the plain strobed port.
module deac_top #(
  parameter int unsigned WRITE_CYCLES = deac_pkg::WRITE_CYCLES_DEF,
  parameter int unsigned PWRT_CYCLES = deac_pkg::PWRT_CYCLES_DEF
) (
  // clock and resets
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic por_n,
  // register port
  input deac_pkg::deac_bus_req_t req,
  output logic [7:0] rdata,
  // program memory and configuration space launch
  output deac_pkg::deac_ext_t ext,
  // status
  output logic write_busy
);

  deac_pkg::deac_state_t s_q;
  deac_pkg::deac_state_t s_d;
  deac_pkg::deac_keep_t k_q;
  deac_pkg::deac_keep_t k_d;

  logic [7:0] mem [0:deac_pkg::ARRAY_DEPTH-1];
  logic mem_we;
  logic [deac_pkg::IDX_W-1:0] mem_waddr;
  logic [7:0] mem_wdata;
  logic [deac_pkg::IDX_W-1:0] idx;
  logic data_target_q;
  logic data_target_new;
  logic launch_ok;

  function automatic logic is_data(input logic space, input logic cfg);
    is_data = !space && !cfg;
  endfunction

  function automatic logic [7:0] control_view(
    input deac_pkg::deac_state_t s,
    input deac_pkg::deac_keep_t k
  );
    control_view = deac_pkg::ZERO_BYTE;
    control_view[deac_pkg::BIT_SPACE] = k.space;
    control_view[deac_pkg::BIT_CFG] = k.cfg;
    control_view[deac_pkg::BIT_ERASE] = s.erase;
    control_view[deac_pkg::BIT_ERROR] = k.error;
    control_view[deac_pkg::BIT_PERMIT] = s.permit;
    control_view[deac_pkg::BIT_WRITE] = s.wr_busy;
  endfunction

  assign idx = {s_q.idx_high, s_q.idx_low};
  assign data_target_q = is_data(k_q.space, k_q.cfg);
  assign data_target_new = is_data(req.wdata[deac_pkg::BIT_SPACE],
    req.wdata[deac_pkg::BIT_CFG]);
  // permit must already be set: the same write cannot enable itself
  assign launch_ok = (s_q.unlk == deac_pkg::UNLK_ARMED) && s_q.permit &&
    k_q.pwrt_done;

  always_comb begin
    s_d = s_q;
    k_d = k_q;
    s_d.ext.start = 1'h0;
    s_d.rdata = deac_pkg::ZERO_BYTE;
    mem_we = 1'h0;
    mem_waddr = idx;
    mem_wdata = s_q.nvm_byte;

    // power-up timer, counted once after power-on
    if (!k_q.pwrt_done) begin
      if (k_q.pwrt_cnt == deac_pkg::CNT_W'(PWRT_CYCLES - 1)) begin
        k_d.pwrt_done = 1'h1;
      end else begin
        k_d.pwrt_cnt = k_q.pwrt_cnt + deac_pkg::CNT_W'(1);
      end
    end

    // register reads, data valid the cycle after the strobe
    if (req.rd) begin
      if (req.addr == deac_pkg::OFS_CONTROL) begin
        s_d.rdata = control_view(s_q, k_q);
      end else if (req.addr == deac_pkg::OFS_UNLOCK) begin
        s_d.rdata = deac_pkg::ZERO_BYTE;
      end else if (req.addr == deac_pkg::OFS_BYTE) begin
        s_d.rdata = s_q.nvm_byte;
      end else if (req.addr == deac_pkg::OFS_IDX_LOW) begin
        s_d.rdata = s_q.idx_low;
      end else if (req.addr == deac_pkg::OFS_IDX_HIGH) begin
        s_d.rdata = {6'h00, s_q.idx_high};
      end else if (req.addr == deac_pkg::OFS_FLAGS_TWO) begin
        s_d.rdata[deac_pkg::BIT_DONE] = s_q.done;
      end else begin
        s_d.rdata = deac_pkg::ZERO_BYTE;
      end
    end

    if (req.wr) begin
      // any write other than the next key breaks the unlock sequence
      s_d.unlk = deac_pkg::UNLK_IDLE;
      if (req.addr == deac_pkg::OFS_UNLOCK) begin
        if (req.wdata == deac_pkg::UNLOCK_FIRST) begin
          s_d.unlk = deac_pkg::UNLK_HALF;
        end else if (req.wdata == deac_pkg::UNLOCK_SECOND &&
                     s_q.unlk == deac_pkg::UNLK_HALF) begin
          s_d.unlk = deac_pkg::UNLK_ARMED;
        end
      end else if (req.addr == deac_pkg::OFS_CONTROL) begin
        if (!s_q.wr_busy) begin
          k_d.space = req.wdata[deac_pkg::BIT_SPACE];
          k_d.cfg = req.wdata[deac_pkg::BIT_CFG];
          k_d.error = req.wdata[deac_pkg::BIT_ERROR];
          s_d.erase = req.wdata[deac_pkg::BIT_ERASE];
          s_d.permit = req.wdata[deac_pkg::BIT_PERMIT];
          if (req.wdata[deac_pkg::BIT_READ] && data_target_new) begin
            // read finishes at this edge, so no read bit stays set
            s_d.nvm_byte = mem[idx];
          end
          if (req.wdata[deac_pkg::BIT_WRITE]) begin
            if (launch_ok) begin
              s_d.wr_busy = 1'h1;
              s_d.wcnt = '0;
              k_d.error = 1'h1;
              if (data_target_new) begin
                mem_we = 1'h1;
                mem_wdata = deac_pkg::ERASED_BYTE;
              end else begin
                s_d.ext.start = 1'h1;
                s_d.ext.config_space = req.wdata[deac_pkg::BIT_CFG];
                s_d.ext.program_space = req.wdata[deac_pkg::BIT_SPACE];
                s_d.ext.erase = req.wdata[deac_pkg::BIT_ERASE];
              end
            end else begin
              k_d.error = 1'h1;
            end
          end
        end
      end else if (req.addr == deac_pkg::OFS_BYTE) begin
        if (!s_q.wr_busy) begin
          s_d.nvm_byte = req.wdata;
        end
      end else if (req.addr == deac_pkg::OFS_IDX_LOW) begin
        if (!s_q.wr_busy) begin
          s_d.idx_low = req.wdata;
        end
      end else if (req.addr == deac_pkg::OFS_IDX_HIGH) begin
        if (!s_q.wr_busy) begin
          s_d.idx_high = req.wdata[deac_pkg::HIGH_W-1:0];
        end
      end else if (req.addr == deac_pkg::OFS_FLAGS_TWO) begin
        s_d.done = req.wdata[deac_pkg::BIT_DONE];
      end
    end

    // self-timed write; placed last so completion beats a clear of done
    if (s_q.wr_busy) begin
      if (s_q.wcnt == deac_pkg::CNT_W'(WRITE_CYCLES - 1)) begin
        s_d.wr_busy = 1'h0;
        k_d.error = 1'h0;
        s_d.done = 1'h1;
        s_d.erase = 1'h0;
        if (data_target_q) begin
          mem_we = 1'h1;
          mem_wdata = s_q.nvm_byte;
        end
      end else begin
        s_d.wcnt = s_q.wcnt + deac_pkg::CNT_W'(1);
      end
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  // survives ordinary resets so an aborted write stays visible
  always_ff @(posedge clk_sys or negedge por_n) begin
    if (!por_n) begin
      k_q <= '0;
    end else begin
      k_q <= k_d;
    end
  end

  // array holds no reset: it is the nonvolatile content
  always_ff @(posedge clk_sys) begin
    if (mem_we) begin
      mem[mem_waddr] <= mem_wdata;
    end
  end

  assign rdata = s_q.rdata;
  assign ext = s_q.ext;
  assign write_busy = s_q.wr_busy;

  // checks
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!resetn);

  logic [deac_pkg::CNT_W-1:0] busy_len;
  logic ctl_wr;
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      busy_len <= '0;
    end else if (s_q.wr_busy) begin
      busy_len <= busy_len + deac_pkg::CNT_W'(1);
    end else begin
      busy_len <= '0;
    end
  end
  assign ctl_wr = req.wr && req.addr == deac_pkg::OFS_CONTROL;

  unlock_launch_a: assert property (
    $rose(s_q.wr_busy) |-> $past(s_q.unlk) == deac_pkg::UNLK_ARMED)
    else $error("write launched without unlock sequence");

  permit_first_a: assert property (
    $rose(s_q.wr_busy) |-> $past(s_q.permit) && s_q.permit)
    else $error("write launched without prior permit");

  pwrt_block_a: assert property (
    !k_q.pwrt_done |-> !s_d.wr_busy && !mem_we)
    else $error("array write during power-up timer");

  write_time_a: assert property (
    $fell(s_q.wr_busy) |-> busy_len == deac_pkg::CNT_W'(WRITE_CYCLES))
    else $error("write duration wrong");

  same_cycle_a: assert property (
    $fell(s_q.wr_busy) |-> s_q.done && !k_q.error && !s_q.erase)
    else $error("completion effects not in one cycle");

  error_launch_a: assert property (
    $rose(s_q.wr_busy) |-> k_q.error ##1 (k_q.error throughout
    s_q.wr_busy[*2]))
    else $error("error flag not set during write");

  frozen_regs_a: assert property (
    s_q.wr_busy ##1 s_q.wr_busy |-> $stable(s_q.idx_low) &&
    $stable(s_q.idx_high) && $stable(s_q.nvm_byte) &&
    $stable(k_q.space) && $stable(k_q.cfg) && $stable(s_q.permit))
    else $error("register changed during write");

  read_byte_a: assert property (
    ctl_wr && !s_q.wr_busy && req.wdata[deac_pkg::BIT_READ] &&
    !req.wdata[deac_pkg::BIT_WRITE] && data_target_new
    |=> s_q.nvm_byte == mem[idx])
    else $error("read byte not presented");

  read_ignored_a: assert property (
    ctl_wr && !s_q.wr_busy && req.wdata[deac_pkg::BIT_READ] &&
    !data_target_new |=> $stable(s_q.nvm_byte))
    else $error("read ran outside data array");

  unlock_zero_a: assert property (
    req.rd && req.addr == deac_pkg::OFS_UNLOCK |=>
    rdata == deac_pkg::ZERO_BYTE)
    else $error("unlock register read nonzero");

  done_sticky_a: assert property (
    s_q.done && !(req.wr && req.addr == deac_pkg::OFS_FLAGS_TWO)
    |=> s_q.done)
    else $error("done flag cleared by hardware");

  // control, data and hardware-owned bits move only on their own events
  launch_clear_a: assert property (
    $fell(s_q.wr_busy) |->
    $past(s_q.wcnt) == deac_pkg::CNT_W'(WRITE_CYCLES - 1))
    else $error("write bit cleared before completion");

  erase_hold_a: assert property (
    s_q.wr_busy ##1 s_q.wr_busy |-> $stable(s_q.erase))
    else $error("erase bit changed during write");

  keep_select_a: assert property (
    !ctl_wr |=> $stable(k_q.space) && $stable(k_q.cfg))
    else $error("space selects changed without control write");

  error_hold_a: assert property (
    k_q.error && !ctl_wr && !s_q.wr_busy |=> k_q.error)
    else $error("error flag cleared by hardware while idle");

  permit_hold_a: assert property (
    !(ctl_wr && !s_q.wr_busy) |=> $stable(s_q.permit))
    else $error("update permit changed without control write");

  byte_hold_a: assert property (
    !(ctl_wr && !s_q.wr_busy && req.wdata[deac_pkg::BIT_READ] &&
    data_target_new) &&
    !(req.wr && !s_q.wr_busy && req.addr == deac_pkg::OFS_BYTE) |=>
    $stable(s_q.nvm_byte))
    else $error("data byte changed without read or write");

  erase_first_a: assert property (
    $rose(s_q.wr_busy) && data_target_q |->
    mem[idx] == deac_pkg::ERASED_BYTE)
    else $error("location not erased at write launch");

  program_last_a: assert property (
    $fell(s_q.wr_busy) && data_target_q |-> mem[idx] == s_q.nvm_byte)
    else $error("new byte not programmed at completion");

  ext_pulse_a: assert property (
    s_q.ext.start |=> !s_q.ext.start)
    else $error("launch pulse longer than one cycle");

  ext_target_a: assert property (
    $rose(s_q.wr_busy) |-> s_q.ext.start == !data_target_q)
    else $error("launch sent to wrong space");

  unlock_break_a: assert property (
    req.wr && req.addr != deac_pkg::OFS_UNLOCK |=>
    s_q.unlk == deac_pkg::UNLK_IDLE)
    else $error("unlock sequence survived another write");

  data_write_c: cover property (
    $rose(s_q.wr_busy) && data_target_q ##[1:1000] $fell(s_q.wr_busy));
  ext_launch_c: cover property (s_q.ext.start && s_q.ext.erase);
  refused_c: cover property (
    ctl_wr && req.wdata[deac_pkg::BIT_WRITE] && !launch_ok && !s_q.wr_busy);
  read_c: cover property (
    ctl_wr && req.wdata[deac_pkg::BIT_READ] && data_target_new);
  done_clear_c: cover property ($fell(s_q.done));

endmodule

// File: tb_data_eeprom_access_control.sv
module tb_data_eeprom_access_control;
  timeunit 1ns;
  timeprecision 1ns;

  localparam int unsigned WCYC = 16;
  localparam int unsigned PCYC = 40;
  localparam logic [2:0] CTL = deac_pkg::OFS_CONTROL;
  localparam logic [2:0] UNL = deac_pkg::OFS_UNLOCK;
  localparam logic [2:0] BYT = deac_pkg::OFS_BYTE;
  localparam logic [2:0] IXL = deac_pkg::OFS_IDX_LOW;
  localparam logic [2:0] IXH = deac_pkg::OFS_IDX_HIGH;
  localparam logic [2:0] FL2 = deac_pkg::OFS_FLAGS_TWO;

  logic clk_sys;
  logic resetn;
  logic por_n;
  deac_pkg::deac_bus_req_t req;
  logic [7:0] rdata;
  deac_pkg::deac_ext_t ext;
  deac_pkg::deac_ext_t ext_seen;
  logic write_busy;
  int num_errors;
  int checks_done;
  int busy_cnt;
  int start_cnt;

  deac_top #(.WRITE_CYCLES(WCYC), .PWRT_CYCLES(PCYC)) dut (
    .clk_sys(clk_sys),
    .resetn(resetn),
    .por_n(por_n),
    .req(req),
    .rdata(rdata),
    .ext(ext),
    .write_busy(write_busy)
  );

  always #50 clk_sys = ~clk_sys;

  // sampled mid-cycle so the edge updates have landed
  always @(negedge clk_sys) begin
    if (write_busy === 1'h1) busy_cnt++;
    if (ext.start === 1'h1) begin
      start_cnt++;
      ext_seen = ext;
    end
  end

  task automatic summarize();
    $display("errors %0d checks %0d", num_errors, checks_done);
    if (num_errors == 0 && checks_done > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  task automatic chk(string nm, logic [7:0] exp, logic [7:0] got);
    checks_done++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic bw(logic [2:0] a, logic [7:0] d);
    @(posedge clk_sys);
    req <= '{addr: a, wdata: d, wr: 1'h1, rd: 1'h0};
    @(posedge clk_sys);
    req <= '0;
  endtask

  // read data stand only in the cycle after the strobe
  task automatic br(logic [2:0] a, logic [7:0] exp, string nm);
    @(posedge clk_sys);
    req <= '{addr: a, wdata: 8'h00, wr: 1'h0, rd: 1'h1};
    @(posedge clk_sys);
    req <= '0;
    @(negedge clk_sys);
    chk(nm, exp, rdata);
  endtask

  task automatic launch(logic [7:0] c);
    bw(CTL, c);
    bw(UNL, deac_pkg::UNLOCK_FIRST);
    bw(UNL, deac_pkg::UNLOCK_SECOND);
    bw(CTL, c | 8'h02);
  endtask

  task automatic chk_idle(string nm);
    @(negedge clk_sys);
    chk(nm, 8'h00, {7'h00, write_busy});
  endtask

  task automatic wait_idle();
    int n;
    n = 0;
    @(negedge clk_sys);
    while (write_busy !== 1'h0 && n < 200) begin
      @(negedge clk_sys);
      n++;
    end
    if (n >= 200) begin
      num_errors++;
      $display("[FAIL] write_busy expected 0 seen %b", write_busy);
      summarize();
    end
  endtask

  task automatic rd_arr(logic [9:0] idx, logic [7:0] exp);
    bw(IXH, {6'h00, idx[9:8]});
    bw(IXL, idx[7:0]);
    bw(CTL, 8'h01);
    br(BYT, exp, "array byte");
  endtask

  task automatic t_reset();
    br(CTL, 8'h00, "control at power-up");
    bw(UNL, deac_pkg::UNLOCK_FIRST);
    br(UNL, 8'h00, "unlock read");
    br(3'h6, 8'h00, "unmapped read");
    br(FL2, 8'h00, "flags at power-up");
  endtask

  task automatic t_pwrt();
    // power-up timer still running here
    launch(8'h04);
    chk_idle("busy early");
    br(CTL, 8'h0C, "control early");
    bw(CTL, 8'h00);
    repeat (PCYC) @(posedge clk_sys);
  endtask

  task automatic t_write(logic [9:0] idx, logic [7:0] d);
    bw(IXH, {6'h00, idx[9:8]});
    bw(IXL, idx[7:0]);
    bw(BYT, d);
    busy_cnt = 0;
    launch(8'h04);
    @(negedge clk_sys);
    chk("busy at launch", 8'h01, {7'h00, write_busy});
    br(CTL, 8'h0E, "control busy");
    bw(CTL, 8'h00);
    bw(BYT, 8'h00);
    bw(IXL, 8'h00);
    br(CTL, 8'h0E, "control frozen");
    wait_idle();
    chk("busy length", WCYC[7:0], busy_cnt[7:0]);
    br(CTL, 8'h04, "control done");
    br(FL2, 8'h10, "done flag");
    br(BYT, d, "byte kept");
    bw(BYT, 8'h5A);
    bw(CTL, 8'h01);
    br(BYT, d, "read back");
    br(CTL, 8'h00, "read bit clear");
    bw(FL2, 8'h00);
    br(FL2, 8'h00, "done cleared");
  endtask

  task automatic try_bad(logic [7:0] c, logic [7:0] k1, logic [7:0] k2);
    bw(CTL, c);
    bw(UNL, k1);
    bw(UNL, k2);
    bw(CTL, 8'h06);
    chk_idle("busy refused");
    br(CTL, 8'h0C, "control refused");
    bw(CTL, 8'h00);
  endtask

  task automatic t_space();
    logic [7:0] c [3] = '{8'h84, 8'h44, 8'h94};
    logic [3:0] e [3] = '{4'hA, 4'hC, 4'hB};
    rd_arr(10'h0FF, 8'h3C);
    bw(IXH, 8'h03);
    bw(CTL, 8'h80);
    bw(CTL, 8'h81);
    br(BYT, 8'h3C, "read in program space");
    bw(CTL, 8'h41);
    br(BYT, 8'h3C, "read in config space");
    for (int i = 0; i < 3; i++) begin
      start_cnt = 0;
      launch(c[i]);
      wait_idle();
      chk("start pulses", 8'h01, start_cnt[7:0]);
      chk("target", {4'h0, e[i]}, {4'h0, ext_seen});
      br(CTL, c[i] & 8'hEF, "control after launch");
    end
    rd_arr(10'h3FF, 8'hA5);
  endtask

  task automatic t_abort();
    launch(8'h84);
    @(posedge clk_sys);
    resetn <= 1'h0;
    repeat (2) @(posedge clk_sys);
    resetn <= 1'h1;
    chk_idle("busy after reset");
    br(CTL, 8'h88, "control after abort");
    bw(CTL, 8'h00);
    br(CTL, 8'h00, "error cleared");
  endtask

  initial begin
    clk_sys = 1'h0;
    resetn = 1'h0;
    por_n = 1'h0;
    req = '0;
    num_errors = 0;
    checks_done = 0;
    busy_cnt = 0;
    start_cnt = 0;
    repeat (8) @(posedge clk_sys);
    resetn <= 1'h1;
    por_n <= 1'h1;
    t_reset();
    t_pwrt();
    t_write(10'h3FF, 8'hA5);
    t_write(10'h0FF, 8'h3C);
    rd_arr(10'h3FF, 8'hA5);
    try_bad(8'h00, 8'h55, 8'hAA);
    try_bad(8'h04, 8'hAA, 8'h55);
    try_bad(8'h04, 8'h55, 8'h55);
    rd_arr(10'h0FF, 8'h3C);
    t_space();
    t_abort();
    summarize();
  end
endmodule
